// ### core/ltf_conv_if.sv
// Carries one finished conversion from the link receiver to the flag logic.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface ltf_conv_if;
    logic        evt;
    logic [15:0] res;
    modport src (output evt, output res);
    modport dst (input evt, input res);
endinterface

// ### core/ltf_fault_cnt.sv
// Counts consecutive conversions that meet one limit comparison.
// Assumes i_evt is a one-cycle pulse per finished conversion.
`timescale 1ns/1ps
module ltf_fault_cnt (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_evt,
    input  wire logic       i_hit,
    input  wire logic [3:0] i_need,
    output logic            o_trip
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [3:0] inc;

    // A miss restarts the run; a met count saturates so that every
    // further matching conversion trips again.
    always_comb begin
        inc     = cnt_ff + 4'h1;
        o_trip  = i_evt & i_hit & (inc >= i_need);
        nxt_cnt = cnt_ff;
        if (i_evt) begin
            nxt_cnt = !i_hit ? 4'h0 : (o_trip ? i_need : inc);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// ### core/ltf_link_rx.sv
// Receives conversion results from the converter link.
// Assumes the link data change away from the rising link clock edge.
`timescale 1ns/1ps
module ltf_link_rx (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_link_clk,
    input  wire logic        i_link_valid,
    input  wire logic [15:0] i_link_data,
    ltf_conv_if.src          o_conv
);
    logic [2:0]  clk_sh_ff;
    logic [2:0]  nxt_clk_sh;
    logic [1:0]  vld_sh_ff;
    logic [1:0]  nxt_vld_sh;
    logic [15:0] dat1_ff;
    logic [15:0] dat2_ff;
    logic        evt_ff;
    logic        nxt_evt;
    logic [15:0] res_ff;
    logic [15:0] nxt_res;
    logic        rise;

    // Edges are found on the second and third stages only, so the first
    // stage never feeds logic and cannot pass metastability on.
    always_comb begin
        nxt_clk_sh = {clk_sh_ff[1:0], i_link_clk};
        nxt_vld_sh = {vld_sh_ff[0], i_link_valid};
        rise       = clk_sh_ff[1] & ~clk_sh_ff[2];
        nxt_evt    = rise & vld_sh_ff[1];
        nxt_res    = rise ? dat2_ff : res_ff;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            clk_sh_ff <= 3'h0;
            vld_sh_ff <= 2'h0;
            dat1_ff   <= 16'h0000;
            dat2_ff   <= 16'h0000;
            evt_ff    <= 1'b0;
            res_ff    <= ltf_pkg::RESULT_RST;
        end else begin
            clk_sh_ff <= nxt_clk_sh;
            vld_sh_ff <= nxt_vld_sh;
            dat1_ff   <= i_link_data;
            dat2_ff   <= dat1_ff;
            evt_ff    <= nxt_evt;
            res_ff    <= nxt_res;
        end
    end

    assign o_conv.evt = evt_ff;
    assign o_conv.res = res_ff;
endmodule

// ### core/ltf_pkg.sv
// Shared constants of the light threshold flag logic: register offsets,
// configuration field positions, reset values and the fault-count table.
// Assumes a 16-bit register port with a 4-bit word address.
package ltf_pkg;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    localparam logic [3:0] OFF_RESULT   = 4'h0;
    localparam logic [3:0] OFF_CONFIG   = 4'h1;
    localparam logic [3:0] OFF_LOW_LIM  = 4'h2;
    localparam logic [3:0] OFF_HIGH_LIM = 4'h3;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h5;

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    localparam int unsigned CFG_FC_LSB   = 0;
    localparam int unsigned CFG_POL      = 3;
    localparam int unsigned CFG_LATCH    = 4;
    localparam int unsigned CFG_FLAG_LO  = 5;
    localparam int unsigned CFG_FLAG_HI  = 6;
    localparam int unsigned CFG_CONV_RDY = 7;
    localparam int unsigned CFG_MODE_LSB = 9;

    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] EXP_TOP_EOC   = 2'h3;

    localparam logic [15:0] CFG_RST      = 16'h0010;
    localparam logic [15:0] LOW_LIM_RST  = 16'h0000;
    localparam logic [15:0] HIGH_LIM_RST = 16'hBFFF;
    localparam logic [15:0] RESULT_RST   = 16'h0000;

    // ------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_CONV   = 0;
    localparam int unsigned IRQ_HIGH   = 1;
    localparam int unsigned IRQ_LOW    = 2;
    localparam int unsigned STAT_PIN   = 15;
    localparam logic [2:0]  IRQ_RST    = 3'h0;

    // Consecutive conversions needed for each fault-count code.
    localparam logic [3:0] FC_NEED [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

endpackage

// ### core/ltf_top.sv
// Threshold comparison, flag keeping and alert pin of the light sensor.
// Assumes a same-clock register master and a separately clocked result link.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ltf_top (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_link_clk,
    input  wire logic        i_link_valid,
    input  wire logic [15:0] i_link_data,
    input  wire logic        i_ara_done,
    output logic             o_ara_claim,
    input  wire logic        i_alert_pin,
    output logic             o_alert_out,
    output logic             o_alert_oe_n,
    output logic             o_irq
);
    // ------------------------------------------------------------------
    // Conversion link and fault counters
    // ------------------------------------------------------------------
    ltf_conv_if conv ();

    logic [15:0] cfg_ff;
    logic [15:0] nxt_cfg;
    logic [15:0] low_ff;
    logic [15:0] nxt_low;
    logic [15:0] high_ff;
    logic [15:0] nxt_high;
    logic [15:0] res_ff;
    logic [15:0] nxt_res;
    logic        trip_hi;
    logic        trip_lo;
    logic        hit_hi;
    logic        hit_lo;
    logic [3:0]  need;

    ltf_link_rx u_link (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_link_clk   (i_link_clk),
        .i_link_valid (i_link_valid),
        .i_link_data  (i_link_data),
        .o_conv       (conv)
    );

    // Results and limits share one mantissa-and-exponent format, so both
    // sides are brought to a common linear scale before comparing.
    function automatic logic [27:0] lin(input logic [15:0] v);
        lin = 28'(v[11:0]) << v[15:12];
    endfunction

    always_comb begin
        need   = ltf_pkg::FC_NEED[cfg_ff[ltf_pkg::CFG_FC_LSB +: 2]];
        hit_hi = lin(conv.res) > lin(high_ff);
        hit_lo = lin(conv.res) < lin(low_ff);
    end

    ltf_fault_cnt u_cnt_hi (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_evt     (conv.evt),
        .i_hit     (hit_hi),
        .i_need    (need),
        .o_trip    (trip_hi)
    );

    ltf_fault_cnt u_cnt_lo (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_evt     (conv.evt),
        .i_hit     (hit_lo),
        .i_need    (need),
        .o_trip    (trip_lo)
    );

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    logic cfg_rd;
    logic cfg_wr;
    logic wr_run;
    logic latch;
    logic output_polarity;
    logic eoc;

    always_comb begin
        cfg_rd = i_rd & (i_addr == ltf_pkg::OFF_CONFIG);
        cfg_wr = i_wr & (i_addr == ltf_pkg::OFF_CONFIG);
        wr_run = cfg_wr
               & (i_wdata[ltf_pkg::CFG_MODE_LSB +: 2] != ltf_pkg::MODE_SHUTDOWN);
        latch  = cfg_ff[ltf_pkg::CFG_LATCH];
        output_polarity    = cfg_ff[ltf_pkg::CFG_POL];
        eoc    = low_ff[15:14] == ltf_pkg::EXP_TOP_EOC;
    end

    // ------------------------------------------------------------------
    // Flags, conversion ready and alert state
    // ------------------------------------------------------------------
    logic fh_ff;
    logic nxt_fh;
    logic fl_ff;
    logic nxt_fl;
    logic crf_ff;
    logic nxt_crf;
    logic alert_ff;
    logic nxt_alert;
    logic oe_n_ff;
    logic nxt_oe_n;

    // Clears are applied first and the conversion second, so a result that
    // lands in the same cycle as a read is never lost.
    always_comb begin
        nxt_fh    = fh_ff;
        nxt_fl    = fl_ff;
        nxt_crf   = crf_ff;
        nxt_alert = alert_ff;
        if (cfg_rd) begin
            nxt_crf = 1'b0;
            if (latch) begin
                nxt_fh    = 1'b0;
                nxt_fl    = 1'b0;
                nxt_alert = 1'b0;
            end else if (eoc) begin
                nxt_alert = 1'b0;
            end
        end
        if (wr_run) begin
            nxt_crf = 1'b0;
            if (!latch && eoc) begin
                nxt_alert = 1'b0;
            end
        end
        if (i_ara_done && latch) begin
            nxt_alert = 1'b0;
        end
        if (conv.evt) begin
            nxt_crf = 1'b1;
            if (latch) begin
                if (trip_hi) begin
                    nxt_fh    = 1'b1;
                    nxt_alert = 1'b1;
                end
                if (trip_lo) begin
                    nxt_fl    = 1'b1;
                    nxt_alert = 1'b1;
                end
            end else begin
                if (trip_hi) begin
                    nxt_fh    = 1'b1;
                    nxt_fl    = 1'b0;
                    nxt_alert = 1'b1;
                end else if (trip_lo) begin
                    nxt_fl    = 1'b1;
                    nxt_fh    = 1'b0;
                    nxt_alert = 1'b0;
                end
            end
            if (eoc) begin
                nxt_alert = 1'b1;
            end
        end
        nxt_oe_n = ~(nxt_alert ^ nxt_cfg[ltf_pkg::CFG_POL]);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fh_ff    <= 1'b0;
            fl_ff    <= 1'b0;
            crf_ff   <= 1'b0;
            alert_ff <= 1'b0;
            oe_n_ff  <= ~ltf_pkg::CFG_RST[ltf_pkg::CFG_POL];
        end else begin
            fh_ff    <= nxt_fh;
            fl_ff    <= nxt_fl;
            crf_ff   <= nxt_crf;
            alert_ff <= nxt_alert;
            oe_n_ff  <= nxt_oe_n;
        end
    end

    // The pad only ever pulls low; the wired line is shared with others.
    assign o_alert_out  = 1'b0;
    assign o_alert_oe_n = oe_n_ff;
    // Transparent mode keeps off the alert response entirely.
    assign o_ara_claim  = latch & alert_ff;

    // ------------------------------------------------------------------
    // Software registers and read-back
    // ------------------------------------------------------------------
    logic [ltf_pkg::IRQ_W-1:0] stat_ff;
    logic [ltf_pkg::IRQ_W-1:0] nxt_stat;
    logic [ltf_pkg::IRQ_W-1:0] mask_ff;
    logic [ltf_pkg::IRQ_W-1:0] nxt_mask;
    logic [ltf_pkg::IRQ_W-1:0] ev;
    logic [ltf_pkg::IRQ_W-1:0] w1c;
    logic [15:0]               rdata_ff;
    logic [15:0]               nxt_rdata;
    logic [15:0]               cfg_view;
    logic [1:0]                pin_sh_ff;

    always_comb begin
        nxt_cfg  = cfg_ff;
        nxt_low  = low_ff;
        nxt_high = high_ff;
        nxt_mask = mask_ff;
        nxt_res  = conv.evt ? conv.res : res_ff;
        if (i_wr) begin
            case (i_addr)
                ltf_pkg::OFF_CONFIG:   nxt_cfg  = i_wdata;
                ltf_pkg::OFF_LOW_LIM:  nxt_low  = i_wdata;
                ltf_pkg::OFF_HIGH_LIM: nxt_high = i_wdata;
                ltf_pkg::OFF_IRQ_MASK: nxt_mask = i_wdata[ltf_pkg::IRQ_W-1:0];
                default:               nxt_cfg  = cfg_ff;
            endcase
        end
        // Status bits are owned by the flag logic, not by software.
        nxt_cfg[ltf_pkg::CFG_FLAG_LO]  = 1'b0;
        nxt_cfg[ltf_pkg::CFG_FLAG_HI]  = 1'b0;
        nxt_cfg[ltf_pkg::CFG_CONV_RDY] = 1'b0;
        ev = '0;
        ev[ltf_pkg::IRQ_CONV] = conv.evt;
        ev[ltf_pkg::IRQ_HIGH] = trip_hi;
        ev[ltf_pkg::IRQ_LOW]  = trip_lo;
        w1c = '0;
        if (i_wr && (i_addr == ltf_pkg::OFF_IRQ_STAT)) begin
            w1c = i_wdata[ltf_pkg::IRQ_W-1:0];
        end
        nxt_stat = (stat_ff & ~w1c) | ev;
        cfg_view = cfg_ff;
        cfg_view[ltf_pkg::CFG_FLAG_LO]  = fl_ff;
        cfg_view[ltf_pkg::CFG_FLAG_HI]  = fh_ff;
        cfg_view[ltf_pkg::CFG_CONV_RDY] = crf_ff;
        nxt_rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                ltf_pkg::OFF_RESULT:   nxt_rdata = res_ff;
                ltf_pkg::OFF_CONFIG:   nxt_rdata = cfg_view;
                ltf_pkg::OFF_LOW_LIM:  nxt_rdata = low_ff;
                ltf_pkg::OFF_HIGH_LIM: nxt_rdata = high_ff;
                ltf_pkg::OFF_IRQ_STAT: begin
                    nxt_rdata[ltf_pkg::IRQ_W-1:0] = stat_ff;
                    nxt_rdata[ltf_pkg::STAT_PIN]  = pin_sh_ff[1];
                end
                ltf_pkg::OFF_IRQ_MASK: nxt_rdata[ltf_pkg::IRQ_W-1:0] = mask_ff;
                default:               nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cfg_ff    <= ltf_pkg::CFG_RST;
            low_ff    <= ltf_pkg::LOW_LIM_RST;
            high_ff   <= ltf_pkg::HIGH_LIM_RST;
            res_ff    <= ltf_pkg::RESULT_RST;
            stat_ff   <= ltf_pkg::IRQ_RST;
            mask_ff   <= ltf_pkg::IRQ_RST;
            rdata_ff  <= 16'h0000;
            pin_sh_ff <= 2'h0;
        end else begin
            cfg_ff    <= nxt_cfg;
            low_ff    <= nxt_low;
            high_ff   <= nxt_high;
            res_ff    <= nxt_res;
            stat_ff   <= nxt_stat;
            mask_ff   <= nxt_mask;
            rdata_ff  <= nxt_rdata;
            pin_sh_ff <= {pin_sh_ff[0], i_alert_pin};
        end
    end

    assign o_rdata = rdata_ff;
    assign o_irq   = |(stat_ff & mask_ff);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_done_read;
        crf_ff && cfg_rd && !conv.evt;
    endsequence

    property p_two_reads;
        s_done_read |=> o_rdata[ltf_pkg::CFG_CONV_RDY] && !crf_ff;
    endproperty
    a_two_reads: assert property (p_two_reads) else $error("ready not cleared by read");

    property p_conv_ready;
        conv.evt |=> crf_ff;
    endproperty
    a_conv_ready: assert property (p_conv_ready) else $error("ready not set");

    property p_lat_high;
        latch && trip_hi && !trip_lo && !cfg_rd && !cfg_wr
            |=> fh_ff && alert_ff && (fl_ff == $past(fl_ff));
    endproperty
    a_lat_high: assert property (p_lat_high) else $error("latched high wrong");

    property p_lat_low;
        latch && trip_lo && !trip_hi && !cfg_rd && !cfg_wr
            |=> fl_ff && alert_ff && (fh_ff == $past(fh_ff));
    endproperty
    a_lat_low: assert property (p_lat_low) else $error("latched low wrong");

    property p_lat_read;
        latch && cfg_rd && !conv.evt && !cfg_wr |=> !fh_ff && !fl_ff && !alert_ff;
    endproperty
    a_lat_read: assert property (p_lat_read) else $error("read did not clear");

    property p_tr_high;
        !latch && !eoc && trip_hi && !cfg_wr |=> fh_ff && !fl_ff && alert_ff;
    endproperty
    a_tr_high: assert property (p_tr_high) else $error("transparent high wrong");

    property p_tr_low;
        !latch && !eoc && trip_lo && !trip_hi && !cfg_wr
            |=> fl_ff && !fh_ff && !alert_ff;
    endproperty
    a_tr_low: assert property (p_tr_low) else $error("transparent low wrong");

    property p_ara;
        latch && i_ara_done && !conv.evt && !cfg_rd && !wr_run
            |=> !alert_ff && $stable(fh_ff) && $stable(fl_ff) && $stable(crf_ff);
    endproperty
    a_ara: assert property (p_ara) else $error("alert response wrong");

    property p_tr_quiet;
        !latch && !eoc && !conv.evt && !cfg_wr && (cfg_rd || i_ara_done)
            |=> $stable(alert_ff) && $stable(fh_ff) && $stable(fl_ff);
    endproperty
    a_tr_quiet: assert property (p_tr_quiet) else $error("transparent flags moved");

    property p_shutdown;
        cfg_wr && !wr_run && !conv.evt && !i_rd && !i_ara_done
            |=> $stable(crf_ff) && $stable(fh_ff) && $stable(fl_ff) && $stable(alert_ff);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown write changed state");

    property p_pin;
        ##1 (o_alert_oe_n == !(alert_ff ^ output_polarity));
    endproperty
    a_pin: assert property (p_pin) else $error("alert pin level wrong");

endmodule

// ### sim/light_threshold_flag_logic_tb.sv
// Self-checking bench of the threshold flag logic with a random result source.
// Assumes a pull-up on the alert wire and no other driver on it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module light_threshold_flag_logic_tb;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_ara_done = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] seed = 16'hCEE9;
    logic [15:0] o_rdata;
    logic        link_clk, link_valid, o_ara_claim, o_alert_out, o_alert_oe_n, o_irq;
    logic [15:0] link_data;
    wire         alert_wire = o_alert_oe_n ? 1'b1 : o_alert_out;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    always #2.5 i_clk = ~i_clk;

    ltf_link_model link_u (.o_link_clk(link_clk), .o_link_valid(link_valid),
        .o_link_data(link_data));
    ltf_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_link_clk(link_clk), .i_link_valid(link_valid), .i_link_data(link_data),
        .i_ara_done(i_ara_done), .o_ara_claim(o_ara_claim), .i_alert_pin(alert_wire),
        .o_alert_out(o_alert_out), .o_alert_oe_n(o_alert_oe_n), .o_irq(o_irq));

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic [15:0] hi();
        return 16'h0900 + (rnd() & 16'h03FF);
    endfunction
    function automatic logic [15:0] lo();
        return rnd() & 16'h00FF;
    endfunction
    function automatic logic [15:0] inr();
        return 16'h0200 + (rnd() & 16'h03FF);
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        `CHK("rdata", e, o_rdata & m)
    endtask
    task automatic pin(input logic e);
        @(negedge i_clk);
        `CHK("alert_wire", e, alert_wire)
    endtask
    // Starting just after an edge keeps both link edges off the system clock edges.
    task automatic conv(input logic [15:0] w);
        @(posedge i_clk);
        #1 link_u.send(w);
        repeat (4) @(posedge i_clk);
    endtask
    task automatic ara();
        @(posedge i_clk);
        i_ara_done <= 1'b1;
        @(posedge i_clk);
        i_ara_done <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(ltf_pkg::OFF_CONFIG, 16'hFFFF, ltf_pkg::CFG_RST);
        rdc(ltf_pkg::OFF_LOW_LIM, 16'hFFFF, ltf_pkg::LOW_LIM_RST);
        rdc(ltf_pkg::OFF_HIGH_LIM, 16'hFFFF, ltf_pkg::HIGH_LIM_RST);
        rdc(4'hF, 16'hFFFF, 16'h0000);
        pin(1'b1);
        wr(ltf_pkg::OFF_HIGH_LIM, 16'h0800);
        wr(ltf_pkg::OFF_LOW_LIM, 16'h0100);
        wr(ltf_pkg::OFF_IRQ_MASK, 16'h0007);
        wr(ltf_pkg::OFF_CONFIG, 16'h0210);
        conv(inr());
        pin(1'b1);
        rdc(ltf_pkg::OFF_IRQ_STAT, 16'h8007, 16'h8001);
        `CHK("irq", 1'b1, o_irq)
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h0080);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h0000);
        conv(hi());
        pin(1'b0);
        conv(lo());
        pin(1'b0);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h00E0);
        pin(1'b1);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h0000);
        conv(hi());
        `CHK("claim", 1'b1, o_ara_claim)
        wr(ltf_pkg::OFF_CONFIG, 16'h0010);
        pin(1'b0);
        ara();
        pin(1'b1);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h00C0);
        wr(ltf_pkg::OFF_CONFIG, 16'h0210);
        conv(hi());
        wr(ltf_pkg::OFF_CONFIG, 16'h0210);
        pin(1'b0);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h0040);
        wr(ltf_pkg::OFF_IRQ_STAT, 16'h0007);
        rdc(ltf_pkg::OFF_IRQ_STAT, 16'h0007, 16'h0000);
        `CHK("irq", 1'b0, o_irq)
        conv(inr());
        `CHK("irq", 1'b1, o_irq)
        wr(ltf_pkg::OFF_IRQ_MASK, 16'h0000);
        `CHK("irq", 1'b0, o_irq)
        wr(ltf_pkg::OFF_CONFIG, 16'h0212);
        for (int i = 0; i < 7; i++) begin
            conv(i == 3 ? inr() : hi());
            pin(1'b1);
        end
        conv(hi());
        pin(1'b0);
        rdc(ltf_pkg::OFF_CONFIG, 16'h0040, 16'h0040);
        wr(ltf_pkg::OFF_CONFIG, 16'h0213);
        conv(inr());
        for (int i = 0; i < 8; i++) begin
            conv(hi());
            pin(i < 7);
        end
        rdc(ltf_pkg::OFF_CONFIG, 16'h0040, 16'h0040);
        wr(ltf_pkg::OFF_CONFIG, 16'h0200);
        conv(hi());
        pin(1'b0);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h00C0);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h0040);
        wr(ltf_pkg::OFF_CONFIG, 16'h0200);
        pin(1'b0);
        `CHK("claim", 1'b0, o_ara_claim)
        ara();
        pin(1'b0);
        conv(lo());
        pin(1'b1);
        rdc(ltf_pkg::OFF_CONFIG, 16'h00E0, 16'h00A0);
        wr(ltf_pkg::OFF_CONFIG, 16'h0209);
        conv(hi());
        pin(1'b0);
        conv(hi());
        pin(1'b1);
        conv(lo());
        pin(1'b1);
        conv(lo());
        pin(1'b0);
        wr(ltf_pkg::OFF_LOW_LIM, 16'hC000);
        wr(ltf_pkg::OFF_CONFIG, 16'h0210);
        rdc(ltf_pkg::OFF_CONFIG, 16'h0080, 16'h0000);
        conv(inr());
        pin(1'b0);
        rdc(ltf_pkg::OFF_CONFIG, 16'h0080, 16'h0080);
        pin(1'b1);
        close_out();
    end
endmodule

// ### sim/ltf_link_model.sv
// Converter side of the result link: sends one result per link clock pulse.
// Assumes the receiver samples data and valid at the rising link clock edge.
`timescale 1ns/1ps
module ltf_link_model (
    output logic        o_link_clk,
    output logic        o_link_valid,
    output logic [15:0] o_link_data
);
    initial begin
        o_link_clk   = 1'b0;
        o_link_valid = 1'b0;
        o_link_data  = 16'h0000;
    end

    // The clock stands still between frames.
    // Released data show the inverse so that a stale word cannot pass.
    task automatic send(input logic [15:0] w);
        o_link_data  = w;
        o_link_valid = 1'b1;
        #62.5 o_link_clk = 1'b1;
        #62.5 o_link_clk = 1'b0;
        o_link_valid = 1'b0;
        o_link_data  = ~w;
    endtask
endmodule
